// [hw/synth_power_ctrl.sv]
// power state, modulator decode and counter-clear control of the synthesizer
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ps

// Behaviour
// - chip enable low powers everything down asynchronously
// - enable high, bits clear: powered up
// - a power-down bit downs only its section
// - auto power-up on N write overrides power-down
// - order field: 0 fourth, 2 second, 3 third
// - dither field: 0 off, 1 weak, 2 strong
// - lock detect output low while powered down
// - N write clears lock and fastlock counters
module synth_power_ctrl
   import synth_pwr_pkg::*;
(
   // clock and reset
   input  wire logic                       sys_clk,
   input  wire logic                       rst_n,
   // register port
   input  wire synth_pwr_pkg::bus_req_t    bus_req,
   output logic [synth_pwr_pkg::DATA_W-1:0] bus_rdata,
   // chip enable pin
   input  wire logic                       chip_en,
   // raw lock indications from the detectors
   input  wire logic                       main_lock_raw,
   input  wire logic                       aux_lock_raw,
   // section power state
   output logic                            main_pwr_up,
   output logic                            aux_pwr_up,
   // counter values towards the dividers
   output logic [synth_pwr_pkg::MAIN_N_W-1:0] main_n_val,
   output logic [synth_pwr_pkg::AUX_N_W-1:0]  aux_n_val,
   // counter clear pulses towards lock detect and fastlock timer
   output logic                            main_cnt_clr,
   output logic                            aux_cnt_clr,
   // modulator settings
   output synth_pwr_pkg::order_t           modulator_order,
   output synth_pwr_pkg::dither_strength_sel_t            dither_mode,
   output logic [1:0]                      slip_reduction_factor,
   // multiplexed lock detect test output
   output logic                            lock_test_out
);
   import synth_pwr_pkg::*;

   // order field decode, shared by the output and the status word
   function automatic order_t order_dec(input logic [1:0] code);
      order_t o;
      o = ORD_3RD;
      if (code == FM_4TH) begin
         o = ORD_4TH;
      end else if (code == FM_2ND) begin
         o = ORD_2ND;
      end else if (code == FM_3RD) begin
         o = ORD_3RD;
      end
      // code 1 is undefined; third order is the safe compromise
      return o;
   endfunction

   // dither field decode, shared by the output and the status word
   function automatic dither_strength_sel_t dither_strength_sel_dec(input logic [1:0] code);
      dither_strength_sel_t d;
      d = DITHER_STRENGTH_SEL_OFF;
      if (code == DITHER_STRENGTH_SEL_WEAK_CODE) begin
         d = DITHER_STRENGTH_SEL_WEAK;
      end else if (code == DITHER_STRENGTH_SEL_STRONG_CODE) begin
         d = DITHER_STRENGTH_SEL_STRONG;
      end
      // code 3 is undefined; dithering stays off
      return d;
   endfunction

   // stored state
   logic [CTRL_W-1:0]   ctrl_r;       // control word
   logic [MAIN_N_W-1:0] main_n_r;     // main N counter word
   logic [AUX_N_W-1:0]  aux_n_r;      // aux N counter word
   logic                main_clr_r;   // main counter clear pulse
   logic                aux_clr_r;    // aux counter clear pulse
   logic                lock_r;       // registered lock selection
   logic [DATA_W-1:0]   rdata_r;      // read data, one cycle late
   logic [DATA_W-1:0]   rdata_nxt;    // read data before the flop

   // decoded strobes
   logic wr_ctrl;                     // control word write
   logic wr_main_n;                   // main N counter write
   logic wr_aux_n;                    // aux N counter write

   // decoded fields
   logic       main_pd;               // main section power-down bit
   logic       aux_pd;                // aux section power-down bit
   logic       auto_powerup_on_n_write;                  // auto power-up enable
   logic [1:0] ld_sel;                // test output selection
   logic       lock_sel_nxt;          // lock selection before the flop
   logic [DATA_W-1:0] status_word;    // live state for software

   // write decode; one strobe at a time, so no priority is needed
   always_comb begin
      wr_ctrl   = 1'b0;
      wr_main_n = 1'b0;
      wr_aux_n  = 1'b0;
      if (bus_req.wr && bus_req.addr == CTRL_OFS) begin
         wr_ctrl = 1'b1;
      end else if (bus_req.wr && bus_req.addr == MAIN_N_OFS) begin
         wr_main_n = 1'b1;
      end else if (bus_req.wr && bus_req.addr == AUX_N_OFS) begin
         wr_aux_n = 1'b1;
      end
   end

   // field views of the control word
   assign main_pd = ctrl_r[MAIN_PD_POS];
   assign aux_pd  = ctrl_r[AUX_PD_POS];
   assign auto_powerup_on_n_write    = ctrl_r[AUTO_POWERUP_ON_N_WRITE_POS];
   assign ld_sel  = ctrl_r[LDSEL_LSB +: 2];

   // control word; an N write with auto power-up clears that section's
   // power-down bit so the override persists after the write
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= CTRL_RST;
      end else if (wr_ctrl) begin
         // order and dither are plain fields, software orders them
         ctrl_r <= bus_req.wdata[CTRL_W-1:0];
      end else if (wr_main_n && auto_powerup_on_n_write) begin
         ctrl_r[MAIN_PD_POS] <= 1'b0;
      end else if (wr_aux_n && auto_powerup_on_n_write) begin
         ctrl_r[AUX_PD_POS] <= 1'b0;
      end
   end

   // main N counter word
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         main_n_r <= MAIN_N_RST;
      end else if (wr_main_n) begin
         main_n_r <= bus_req.wdata[MAIN_N_W-1:0];
      end
   end

   // aux N counter word
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         aux_n_r <= AUX_N_RST;
      end else if (wr_aux_n) begin
         aux_n_r <= bus_req.wdata[AUX_N_W-1:0];
      end
   end

   // counter clear pulses; they reset lock detect and fastlock timing
   // counts but load nothing into them
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         main_clr_r <= 1'b0;
         aux_clr_r  <= 1'b0;
      end else begin
         main_clr_r <= wr_main_n;
         aux_clr_r  <= wr_aux_n;
      end
   end

   // power state per section; combinational so chip enable acts
   // without waiting for a clock edge
   always_comb begin
      // each section looks only at its own bit
      main_pwr_up = chip_en && !main_pd;
      aux_pwr_up  = chip_en && !aux_pd;
      // the same-cycle N write with auto power-up wins over the bit
      if (chip_en && auto_powerup_on_n_write && wr_main_n) begin
         main_pwr_up = 1'b1;
      end
      if (chip_en && auto_powerup_on_n_write && wr_aux_n) begin
         aux_pwr_up = 1'b1;
      end
   end

   // lock selection; a detector of a downed section counts as unlocked
   always_comb begin
      lock_sel_nxt = 1'b0;
      if (ld_sel == LD_SEL_MAIN) begin
         lock_sel_nxt = main_lock_raw;
      end else if (ld_sel == LD_SEL_AUX) begin
         lock_sel_nxt = aux_lock_raw;
      end else if (ld_sel == LD_SEL_BOTH) begin
         // either side out of lock shows unlocked
         lock_sel_nxt = main_lock_raw && aux_lock_raw;
      end
   end

   // registered lock view
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         lock_r <= 1'b0;
      end else begin
         lock_r <= lock_sel_nxt;
      end
   end

   // forced low at once while the selected section is down; the
   // gate sits after the flop so the forcing needs no clock
   always_comb begin
      lock_test_out = lock_r;
      if (ld_sel == LD_SEL_LOW) begin
         // nothing viewed: low at once, not a cycle late via the flop
         lock_test_out = 1'b0;
      end else if (ld_sel == LD_SEL_MAIN && !main_pwr_up) begin
         lock_test_out = 1'b0;
      end else if (ld_sel == LD_SEL_AUX && !aux_pwr_up) begin
         lock_test_out = 1'b0;
      end else if (ld_sel == LD_SEL_BOTH && !(main_pwr_up && aux_pwr_up))
      begin
         lock_test_out = 1'b0;
      end
   end

   // live status for software
   always_comb begin
      status_word = '0;
      status_word[ST_MAIN_UP_POS] = main_pwr_up;
      status_word[ST_AUX_UP_POS]  = aux_pwr_up;
      status_word[ST_CE_POS]      = chip_en;
      status_word[ST_ORDER_LSB +: 3] = order_dec(ctrl_r[ORDER_LSB +: 2]);
      status_word[ST_DITHER_STRENGTH_SEL_LSB +: 3]  = dither_strength_sel_dec(ctrl_r[DITHER_STRENGTH_SEL_LSB +: 2]);
      // flags an order code that has no defined meaning
      status_word[ST_ORD_RSV_POS] = (ctrl_r[ORDER_LSB +: 2] == 2'h1);
   end

   // read decode; unmapped offsets read as zero
   always_comb begin
      rdata_nxt = '0;
      if (bus_req.addr == CTRL_OFS) begin
         rdata_nxt[CTRL_W-1:0] = ctrl_r;
      end else if (bus_req.addr == MAIN_N_OFS) begin
         rdata_nxt[MAIN_N_W-1:0] = main_n_r;
      end else if (bus_req.addr == AUX_N_OFS) begin
         rdata_nxt[AUX_N_W-1:0] = aux_n_r;
      end else if (bus_req.addr == STATUS_OFS) begin
         rdata_nxt = status_word;
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= '0;
      end else if (bus_req.rd) begin
         rdata_r <= rdata_nxt;
      end else begin
         rdata_r <= '0;
      end
   end

   // outputs
   assign bus_rdata             = rdata_r;
   assign main_n_val            = main_n_r;
   assign aux_n_val             = aux_n_r;
   assign main_cnt_clr          = main_clr_r;
   assign aux_cnt_clr           = aux_clr_r;
   assign modulator_order       = order_dec(ctrl_r[ORDER_LSB +: 2]);
   assign dither_mode           = dither_strength_sel_dec(ctrl_r[DITHER_STRENGTH_SEL_LSB +: 2]);
   // software must pair this with matching pump settings
   assign slip_reduction_factor = ctrl_r[SLIP_LSB +: 2];

endmodule

// [hw/synth_pwr_pkg.sv]
// constants, field layout and types for the synthesizer power controller
package synth_pwr_pkg;

   // register bus widths
   localparam int ADDR_W     = 8;
   localparam int DATA_W     = 32;

   // register byte offsets
   localparam logic [ADDR_W-1:0] CTRL_OFS   = 8'h00;
   localparam logic [ADDR_W-1:0] MAIN_N_OFS = 8'h04;
   localparam logic [ADDR_W-1:0] AUX_N_OFS  = 8'h08;
   localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h0c;

   // control register field positions
   localparam int MAIN_PD_POS = 0;
   localparam int AUX_PD_POS  = 1;
   localparam int AUTO_POWERUP_ON_N_WRITE_POS    = 2;
   localparam int ORDER_LSB   = 3;
   localparam int DITHER_STRENGTH_SEL_LSB    = 5;
   localparam int SLIP_LSB    = 7;
   localparam int LDSEL_LSB   = 9;
   localparam int CTRL_W      = 11;

   // status register field positions
   localparam int ST_MAIN_UP_POS = 0;
   localparam int ST_AUX_UP_POS  = 1;
   localparam int ST_CE_POS      = 2;
   localparam int ST_ORDER_LSB   = 3;
   localparam int ST_DITHER_STRENGTH_SEL_LSB    = 6;
   localparam int ST_ORD_RSV_POS = 9;

   // counter word widths
   localparam int MAIN_N_W = 23;
   localparam int AUX_N_W  = 19;

   // reset values: third order, no dither, both sections enabled
   localparam logic [CTRL_W-1:0]   CTRL_RST   = 11'h018;
   localparam logic [MAIN_N_W-1:0] MAIN_N_RST = 23'h000000;
   localparam logic [AUX_N_W-1:0]  AUX_N_RST  = 19'h00000;

   // modulator order field codes
   localparam logic [1:0] FM_4TH = 2'h0;
   localparam logic [1:0] FM_2ND = 2'h2;
   localparam logic [1:0] FM_3RD = 2'h3;

   // dither field codes
   localparam logic [1:0] DITHER_STRENGTH_SEL_NONE_CODE   = 2'h0;
   localparam logic [1:0] DITHER_STRENGTH_SEL_WEAK_CODE   = 2'h1;
   localparam logic [1:0] DITHER_STRENGTH_SEL_STRONG_CODE = 2'h2;

   // lock detect test output selections
   localparam logic [1:0] LD_SEL_LOW  = 2'h0;
   localparam logic [1:0] LD_SEL_MAIN = 2'h1;
   localparam logic [1:0] LD_SEL_AUX  = 2'h2;
   localparam logic [1:0] LD_SEL_BOTH = 2'h3;

   // decoded modulator order, one-hot
   typedef enum logic [2:0] {
      ORD_2ND = 3'b001,
      ORD_3RD = 3'b010,
      ORD_4TH = 3'b100
   } order_t;

   // decoded dither strength, one-hot
   typedef enum logic [2:0] {
      DITHER_STRENGTH_SEL_OFF    = 3'b001,
      DITHER_STRENGTH_SEL_WEAK   = 3'b010,
      DITHER_STRENGTH_SEL_STRONG = 3'b100
   } dither_strength_sel_t;

   // one register bus request
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } bus_req_t;

endpackage

// [verif/host_model.sv]
// host controller model: issues register requests one per cycle
`timescale 1ns/1ps
module host_model
   import synth_pwr_pkg::*;
(
   // clock
   input wire logic                sys_clk,
   // register port towards the block
   output synth_pwr_pkg::bus_req_t bus_req
);
   bus_req_t pend[$]; // queued requests, sent back to back

   initial bus_req = '0;
   // idle lines toggle so a stale value is never mistaken for a request
   always @(posedge sys_clk) begin
      if (pend.size() != 0) bus_req <= pend.pop_front();
      else bus_req <= '{~bus_req.addr, ~bus_req.wdata, 1'b0, 1'b0};
   end

   // queue one write (w=1) or read (w=0)
   task automatic put(input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d, input logic w);
      pend.push_back(bus_req_t'{a, d, w, !w});
   endtask
endmodule

// [verif/synth_pwr_asserts.sv]
// port assertions for the synthesizer power controller
`timescale 1ns/1ps
module synth_pwr_asserts
   import synth_pwr_pkg::*;
(
   // clock and reset
   input wire logic               sys_clk,
   input wire logic               rst_n,
   // observed ports
   input synth_pwr_pkg::bus_req_t bus_req,
   input wire logic               chip_en,
   input wire logic               main_pwr_up,
   input wire logic               aux_pwr_up,
   input wire logic               main_cnt_clr,
   input wire logic               aux_cnt_clr,
   input synth_pwr_pkg::order_t   modulator_order,
   input synth_pwr_pkg::dither_strength_sel_t    dither_mode,
   input wire logic               lock_test_out
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // decoded write strobes and fields
   wire       wc = bus_req.wr && bus_req.addr == CTRL_OFS;
   wire       wm = bus_req.wr && bus_req.addr == MAIN_N_OFS;
   wire       wa = bus_req.wr && bus_req.addr == AUX_N_OFS;
   wire [1:0] fo = bus_req.wdata[ORDER_LSB +: 2];
   wire [1:0] fd = bus_req.wdata[DITHER_STRENGTH_SEL_LSB +: 2];

   AST_CE_DOWN: assert property (!chip_en |-> !main_pwr_up && !aux_pwr_up)
      else $error("section up while chip enable low");
   AST_MAIN_PD: assert property (wc ##1 chip_en && !bus_req.wr |->
      main_pwr_up == !$past(bus_req.wdata[MAIN_PD_POS]))
      else $error("main power state differs from its bit");
   AST_AUX_PD: assert property (wc ##1 chip_en && !bus_req.wr |->
      aux_pwr_up == !$past(bus_req.wdata[AUX_PD_POS]))
      else $error("aux power state differs from its bit");
   AST_AUTO_POWERUP_ON_N_WRITE: assert property (wc && bus_req.wdata[AUTO_POWERUP_ON_N_WRITE_POS] ##1 wm && chip_en
      |-> main_pwr_up) else $error("auto power-up missed");
   AST_MAIN_CLR: assert property (main_cnt_clr == $past(wm))
      else $error("main counter clear pulse wrong");
   AST_AUX_CLR: assert property (aux_cnt_clr == $past(wa))
      else $error("aux counter clear pulse wrong");
   AST_ORDER: assert property (wc |=> modulator_order ==
      ($past(fo) == FM_4TH ? ORD_4TH : $past(fo) == FM_2ND ? ORD_2ND : ORD_3RD))
      else $error("modulator order decode wrong");
   AST_DITHER_STRENGTH_SEL: assert property (wc |=> dither_mode ==
      ($past(fd) == DITHER_STRENGTH_SEL_WEAK_CODE ? DITHER_STRENGTH_SEL_WEAK :
       $past(fd) == DITHER_STRENGTH_SEL_STRONG_CODE ? DITHER_STRENGTH_SEL_STRONG : DITHER_STRENGTH_SEL_OFF))
      else $error("dither decode wrong");
   AST_LD_LOW: assert property (!main_pwr_up && !aux_pwr_up |-> !lock_test_out)
      else $error("lock view high while powered down");

   // main scenarios reached
   CV_AUTO_POWERUP_ON_N_WRITE: cover property (wc && bus_req.wdata[AUTO_POWERUP_ON_N_WRITE_POS] ##1 wm && chip_en);
   CV_CE: cover property ($fell(chip_en));
   CV_LOCK: cover property ($rose(lock_test_out));
endmodule

bind synth_power_ctrl synth_pwr_asserts i_chk (.sys_clk, .rst_n, .bus_req,
   .chip_en, .main_pwr_up, .aux_pwr_up, .main_cnt_clr, .aux_cnt_clr,
   .modulator_order, .dither_mode, .lock_test_out);

// [verif/tb.sv]
// self-checking bench for the synthesizer power controller
`timescale 1ns/1ps
module tb;
   import synth_pwr_pkg::*;
   logic              sys_clk = 1'b0;
   logic              rst_n = 1'b0;
   logic              chip_en = 1'b1;
   logic              main_lock_raw = 1'b0;
   logic              aux_lock_raw = 1'b0;
   logic              lock_rand = 1'b1; // random lock levels when high
   logic              rd_q = 1'b0;      // read taken at last edge
   bus_req_t          bus_req;
   logic [DATA_W-1:0] bus_rdata, cw, expq[$];
   logic              main_pwr_up, aux_pwr_up, main_cnt_clr, aux_cnt_clr;
   logic              lock_test_out;
   logic [1:0]        slip_reduction_factor, pd;
   logic [22:0]       nv;
   logic [MAIN_N_W-1:0] main_n_val;
   logic [AUX_N_W-1:0]  aux_n_val;
   order_t            modulator_order;
   dither_strength_sel_t             dither_mode;
   integer            seed = 65023;
   int                mismatches = 0;
   int                checks = 0;
   int                n;
   // code tables and their decoded forms
   logic [1:0]  oc[3] = '{FM_4TH, FM_2ND, FM_3RD};
   order_t      oe[3] = '{ORD_4TH, ORD_2ND, ORD_3RD};
   logic [1:0]  dc[3] = '{DITHER_STRENGTH_SEL_NONE_CODE, DITHER_STRENGTH_SEL_WEAK_CODE, DITHER_STRENGTH_SEL_STRONG_CODE};
   dither_strength_sel_t       de[3] = '{DITHER_STRENGTH_SEL_OFF, DITHER_STRENGTH_SEL_WEAK, DITHER_STRENGTH_SEL_STRONG};
   logic [31:0] lw[4] = '{32'h600, 32'h201, 32'h402, 32'h000};

   always #4 sys_clk = ~sys_clk; // 125 MHz

   host_model i_host (.sys_clk, .bus_req);
   synth_power_ctrl i_dut (.sys_clk, .rst_n, .bus_req, .bus_rdata, .chip_en,
      .main_lock_raw, .aux_lock_raw, .main_pwr_up, .aux_pwr_up, .main_n_val,
      .aux_n_val, .main_cnt_clr, .aux_cnt_clr, .modulator_order,
      .dither_mode, .slip_reduction_factor, .lock_test_out);

   // lock levels and read tracking
   always @(posedge sys_clk) begin
      rd_q <= bus_req.rd;
      {main_lock_raw, aux_lock_raw} <= lock_rand ? 2'($random(seed)) : 2'b11;
   end
   // read data stands one cycle only: compare mid-cycle
   always @(negedge sys_clk) begin
      if (rd_q) chk("rdata", expq.pop_front(), bus_rdata);
   end

   task automatic chk(input string nm, input logic [31:0] e, s);
      checks++;
      if (s !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // wait, bounded, until every queued request was taken
   task automatic go();
      // step 1 ns past each edge so new requests never race the host pop
      for (n = 0; n < 64 && i_host.pend.size() != 0; n++) begin
         @(posedge sys_clk);
         #1;
      end
      if (n == 64) begin
         mismatches++;
         test_done();
      end
      @(posedge sys_clk);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      expq.push_back(e);
      i_host.put(a, '0, 1'b0);
   endtask
   function automatic logic [31:0] st(logic mu, au, ce, logic [2:0] o, d);
      return {23'h0, d, o, ce, au, mu};
   endfunction

   initial begin
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      #1;
      rd(CTRL_OFS, 32'(CTRL_RST));
      rd(STATUS_OFS, st(1, 1, 1, ORD_3RD, DITHER_STRENGTH_SEL_OFF));
      // every defined order and dither code, random power-down bits
      for (int i = 0; i < 3; i++) begin
         for (int j = 0; j < 3; j++) begin
            pd = 2'($random(seed));
            cw = 32'(oc[i]) << ORDER_LSB | 32'(pd);
            i_host.put(CTRL_OFS, cw, 1'b1);
            cw = cw | 32'(dc[j]) << DITHER_STRENGTH_SEL_LSB | 32'(j) << SLIP_LSB;
            i_host.put(CTRL_OFS, cw, 1'b1);
            rd(CTRL_OFS, cw);
            rd(STATUS_OFS, st(!pd[0], !pd[1], 1, oe[i], de[j]));
            go();
            chk("mode", {26'h0, oe[i], de[j]},
                {26'h0, modulator_order, dither_mode});
            chk("slip", 32'(j), 32'(slip_reduction_factor));
         end
      end
      // auto power-up on N writes, the main one back to back with the control write
      nv = 23'($random(seed)) & 23'hfff;
      i_host.put(CTRL_OFS, 32'h007, 1'b1);
      i_host.put(MAIN_N_OFS, 32'(nv), 1'b1);
      go();
      #1 chk("clr", 32'h1, {aux_cnt_clr, main_cnt_clr});
      chk("main_n", 32'(nv), 32'(main_n_val));
      rd(STATUS_OFS, st(1, 0, 1, ORD_4TH, DITHER_STRENGTH_SEL_OFF));
      i_host.put(AUX_N_OFS, 32'(nv), 1'b1);
      rd(STATUS_OFS, st(1, 1, 1, ORD_4TH, DITHER_STRENGTH_SEL_OFF));
      go();
      chk("aux_n", 32'(nv[AUX_N_W-1:0]), 32'(aux_n_val));
      // chip enable drops; an auto power-up N write must not wake it
      @(posedge sys_clk) chip_en <= 1'b0;
      #1 chk("ups", 32'h0, {main_pwr_up, aux_pwr_up});
      i_host.put(MAIN_N_OFS, 32'(nv), 1'b1);
      rd(STATUS_OFS, st(0, 0, 0, ORD_4TH, DITHER_STRENGTH_SEL_OFF));
      go();
      @(posedge sys_clk) chip_en <= 1'b1;
      #1;
      // lock view: high when viewed sections are up, else held low
      i_host.put(CTRL_OFS, 32'h603, 1'b1);
      go();
      repeat (3) @(negedge sys_clk) chk("ld_off", 0, lock_test_out);
      lock_rand <= 1'b0;
      for (int k = 0; k < 4; k++) begin
         i_host.put(CTRL_OFS, lw[k], 1'b1);
         go();
         repeat (2) @(posedge sys_clk);
         #1 chk("ld", 32'(k == 0), 32'(lock_test_out));
      end
      repeat (3) @(posedge sys_clk);
      test_done();
   end
endmodule
